// ===== verilog/plc_defines.svh
`ifndef PLC_DEFINES_SVH
`define PLC_DEFINES_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define PLC_ADDR_MODE 10'h010
`define PLC_ADDR_RISE 10'h011
`define PLC_ADDR_LOW 10'h012
`define PLC_ADDR_HIGH 10'h013
`define PLC_ADDR_TIME 10'h014
`define PLC_ADDR_CTRL 10'h015
`define PLC_ADDR_LIMIT 10'h016

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PLC_RST_MODE 1'h0
`define PLC_RST_RISE 8'h1E
`define PLC_RST_LOW 6'h1E
`define PLC_RST_HIGH 10'h0C8
`define PLC_RST_TIME 12'h12C
`define PLC_RST_CTRL 16'h0505
`define PLC_RST_LIMIT 16'h9BA3

// ----------------------------------------
// Field positions and limits
// ----------------------------------------
`define PLC_DECR_MSB 15
`define PLC_DECR_LSB 8
`define PLC_OV_MSB 7
`define PLC_OV_LSB 6
`define PLC_STEP_MSB 5
`define PLC_STEP_LSB 4
`define PLC_SEC_MSB 3
`define PLC_SEC_LSB 0
`define PLC_RISE_MIN 8'h01
`define PLC_RISE_MAX 8'hFE
`define PLC_ADC_FULL 8'hFF
`define PLC_LIMIT_SHIFT 7

// ----------------------------------------
// Timing
// ----------------------------------------
`define PLC_CLK_MHZ 100
`define PLC_UNIT_US 10
`define PLC_TICK_CYC (`PLC_UNIT_US * `PLC_CLK_MHZ)
`define PLC_SEC_US 1000000
`define PLC_SEC_TICKS (`PLC_SEC_US / `PLC_UNIT_US)

`endif

// ===== verilog/plc_pkg.sv
package plc_pkg;
	typedef enum {PLC_ARMED, PLC_PULSE, PLC_SPENT} plc_state_t;
	typedef logic [9:0] plc_addr_t;
	typedef logic [15:0] plc_word_t;
endpackage

// ===== verilog/plc_pulse_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "plc_defines.svh"

module plc_pulse_timer #(
	parameter int TW = 12,
	parameter int TICK_CYC = `PLC_TICK_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Control
	input wire logic start,
	input wire logic [TW-1:0] units,
	// Status
	output logic busy
);
	logic [TW-1:0] remain;
	logic [TW-1:0] held;
	logic [31:0] cyc_cnt;
	logic [31:0] unit_cnt;
	logic unit_end;

	// Unit phase restarts at each start, so no pulse is cut short
	assign unit_end = (unit_cnt == 32'(TICK_CYC - 1));

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			busy <= 1'b0;
			remain <= '0;
			held <= '0;
			unit_cnt <= '0;
		end else if (start) begin
			busy <= 1'b1;
			remain <= units;
			held <= units;
			unit_cnt <= '0;
		end else if (busy) begin
			unit_cnt <= unit_end ? '0 : unit_cnt + 32'h1;
			if (unit_end) begin
				remain <= remain - 1'b1;
				if (remain == {{(TW-1){1'b0}}, 1'b1}) begin
					busy <= 1'b0;
				end
			end
		end
	end

	// Helper: cycles spent busy
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cyc_cnt <= '0;
		end else if (start) begin
			cyc_cnt <= '0;
		end else if (busy) begin
			cyc_cnt <= cyc_cnt + 32'h1;
		end
	end

	pulse_start_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		start |=> busy && remain == $past(units))
		else $error("timer did not load on start");
	pulse_len_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		busy |-> cyc_cnt <= 32'(held) * 32'(TICK_CYC))
		else $error("pulse longer than programmed time");
	pulse_full_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		$fell(busy) |-> cyc_cnt == 32'(held) * 32'(TICK_CYC))
		else $error("pulse shorter than programmed time");
endmodule
`default_nettype wire

// ===== verilog/plc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "plc_defines.svh"

module plc_top import plc_pkg::*; #(
	parameter int TICK_CYC = `PLC_TICK_CYC,
	parameter int SEC_TICKS = `PLC_SEC_TICKS,
	parameter int ACC_W = 24
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire plc_addr_t reg_addr,
	input wire plc_word_t reg_wdata,
	output plc_word_t reg_rdata,
	// Converter samples
	input wire logic adc_valid,
	input wire logic [7:0] adc_sample,
	// Current sink
	output logic [10:0] load_sink_pin,
	output logic pulse_active,
	output logic cool_active
);
	// ----------------------------------------
	// Field clamps and sample scaling
	// ----------------------------------------
	function automatic logic [7:0] clamp_rise(input logic [7:0] v);
		if (v == 8'h00) begin
			return `PLC_RISE_MIN;
		end else if (v == `PLC_ADC_FULL) begin
			return `PLC_RISE_MAX;
		end
		return v;
	endfunction

	function automatic logic [11:0] clamp_nonzero(input logic [11:0] v);
		return (v == 12'h000) ? 12'h001 : v;
	endfunction

	function automatic logic [11:0] scale_adc(input logic [7:0] a, input logic [1:0] ov);
		if (a != `PLC_ADC_FULL) begin
			return {4'h0, a};
		end
		unique case (ov)
			2'h0: return {4'h0, a};
			2'h1: return {2'h0, a, 2'h0};
			2'h2: return {1'h0, a, 3'h0};
			2'h3: return {a, 4'h0};
		endcase
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic load_idle_select;
	logic [7:0] rising_threshold;
	logic [5:0] load_low_current_code;
	logic [9:0] load_high_current_code;
	logic [11:0] load_high_pulse_time;
	logic [7:0] cool_decrement;
	logic [1:0] overvoltage_factor;
	logic [1:0] cool_step_interval;
	logic [3:0] cool_period_seconds;
	logic [15:0] energy_limit;
	logic [7:0] adc_last;
	plc_word_t next_rdata;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			load_idle_select <= `PLC_RST_MODE;
			rising_threshold <= `PLC_RST_RISE;
			load_low_current_code <= `PLC_RST_LOW;
			load_high_current_code <= `PLC_RST_HIGH;
			load_high_pulse_time <= `PLC_RST_TIME;
			cool_decrement <= 8'(`PLC_RST_CTRL >> `PLC_DECR_LSB);
			overvoltage_factor <= 2'(`PLC_RST_CTRL >> `PLC_OV_LSB);
			cool_step_interval <= 2'(`PLC_RST_CTRL >> `PLC_STEP_LSB);
			cool_period_seconds <= 4'(`PLC_RST_CTRL);
			energy_limit <= `PLC_RST_LIMIT;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`PLC_ADDR_MODE: load_idle_select <= reg_wdata[0];
				`PLC_ADDR_RISE: rising_threshold <= clamp_rise(reg_wdata[7:0]);
				`PLC_ADDR_LOW: load_low_current_code <= 6'(clamp_nonzero({6'h00, reg_wdata[5:0]}));
				`PLC_ADDR_HIGH: load_high_current_code <= reg_wdata[9:0];
				`PLC_ADDR_TIME: load_high_pulse_time <= clamp_nonzero(reg_wdata[11:0]);
				`PLC_ADDR_CTRL: begin
					cool_decrement <= reg_wdata[`PLC_DECR_MSB:`PLC_DECR_LSB];
					overvoltage_factor <= reg_wdata[`PLC_OV_MSB:`PLC_OV_LSB];
					cool_step_interval <= reg_wdata[`PLC_STEP_MSB:`PLC_STEP_LSB];
					cool_period_seconds <= reg_wdata[`PLC_SEC_MSB:`PLC_SEC_LSB];
				end
				`PLC_ADDR_LIMIT: energy_limit <= reg_wdata;
				default: ;
			endcase
		end
	end

	always_comb begin
		next_rdata = 16'h0000;
		unique case (reg_addr)
			`PLC_ADDR_MODE: next_rdata = {15'h0000, load_idle_select};
			`PLC_ADDR_RISE: next_rdata = {8'h00, rising_threshold};
			`PLC_ADDR_LOW: next_rdata = {10'h000, load_low_current_code};
			`PLC_ADDR_HIGH: next_rdata = {6'h00, load_high_current_code};
			`PLC_ADDR_TIME: next_rdata = {4'h0, load_high_pulse_time};
			`PLC_ADDR_CTRL: begin
				next_rdata = {cool_decrement, overvoltage_factor, cool_step_interval,
					cool_period_seconds};
			end
			`PLC_ADDR_LIMIT: next_rdata = energy_limit;
			default: next_rdata = 16'h0000;
		endcase
	end

	// Read data held until the next read
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			adc_last <= 8'h00;
		end else if (adc_valid) begin
			adc_last <= adc_sample;
		end
	end

	// ----------------------------------------
	// Time base
	// ----------------------------------------
	logic [15:0] tick_cnt;
	logic tick;
	logic [2:0] step_cnt;
	logic step_tick;

	assign tick = (tick_cnt == 16'(TICK_CYC - 1));
	assign step_tick = tick && (step_cnt == 3'((1 << cool_step_interval) - 1));

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt <= 16'h0000;
			step_cnt <= 3'h0;
		end else begin
			tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
			if (step_tick) begin
				step_cnt <= 3'h0;
			end else if (tick) begin
				step_cnt <= step_cnt + 3'h1;
			end
		end
	end

	// ----------------------------------------
	// Load state machine
	// ----------------------------------------
	plc_state_t state;
	logic cooling;
	logic timer_busy;
	logic pulse_arm;
	logic pulse_on;
	logic adc_live;
	logic [10:0] next_sink;

	assign adc_live = (adc_last != 8'h00);
	assign pulse_arm = !load_idle_select && state == PLC_ARMED && adc_last > rising_threshold
		&& !cooling;
	assign pulse_on = !cooling && ((state == PLC_PULSE && timer_busy) || (load_idle_select && adc_live));

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= PLC_ARMED;
		end else if (load_idle_select) begin
			state <= PLC_ARMED;
		end else begin
			unique case (state)
				PLC_ARMED: if (pulse_arm) begin
					state <= PLC_PULSE;
				end
				// pulse ends on timer or cool-down
				PLC_PULSE: if (!timer_busy || cooling) begin
					state <= PLC_SPENT;
				end
				// Re-arm after the sample falls back, or whenever load_idle_select is set
				PLC_SPENT: if (adc_last <= rising_threshold) begin
					state <= PLC_ARMED;
				end
			endcase
		end
	end

	plc_pulse_timer #(
		.TW(12),
		.TICK_CYC(TICK_CYC)
	) u_timer (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.start(pulse_arm),
		.units(load_high_pulse_time),
		.busy(timer_busy)
	);

	always_comb begin
		if (!adc_live) begin
			next_sink = 11'h000;
		end else if (pulse_on) begin
			next_sink = {load_high_current_code, 1'b0};
		end else begin
			next_sink = {5'h00, load_low_current_code};
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			load_sink_pin <= 11'h000;
			pulse_active <= 1'b0;
		end else begin
			load_sink_pin <= next_sink;
			pulse_active <= pulse_on;
		end
	end

	// ----------------------------------------
	// Energy meter
	// ----------------------------------------
	logic [ACC_W-1:0] acc;
	logic [ACC_W-1:0] limit_scaled;
	logic [ACC_W:0] acc_sum;
	logic [11:0] scaled;
	logic [31:0] sec_cnt;
	logic [3:0] cool_secs;

	assign scaled = scale_adc(adc_last, overvoltage_factor);
	assign acc_sum = {1'b0, acc} + (ACC_W + 1)'(scaled);
	assign limit_scaled = ACC_W'({energy_limit, 7'h00});

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc <= '0;
		end else if (tick && pulse_on) begin
			acc <= acc_sum[ACC_W] ? '1 : acc_sum[ACC_W-1:0];
		end else if (step_tick && !pulse_on) begin
			acc <= (acc > ACC_W'(cool_decrement)) ? acc - ACC_W'(cool_decrement) : '0;
		end
	end

	// enter over limit, leave after period
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cooling <= 1'b0;
			sec_cnt <= '0;
			cool_secs <= 4'h0;
		end else if (cool_period_seconds == 4'h0) begin
			cooling <= 1'b0;
		end else if (!cooling) begin
			sec_cnt <= '0;
			cool_secs <= 4'h0;
			cooling <= (acc > limit_scaled);
		end else if (tick) begin
			if (sec_cnt == 32'(SEC_TICKS - 1)) begin
				sec_cnt <= '0;
				cool_secs <= cool_secs + 4'h1;
				if (cool_secs + 4'h1 >= cool_period_seconds) begin
					cooling <= 1'b0;
				end
			end else begin
				sec_cnt <= sec_cnt + 32'h1;
			end
		end
	end

	assign cool_active = cooling;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence arm_seen;
		!load_idle_select && state == PLC_ARMED && adc_last > rising_threshold && !cooling;
	endsequence
	sequence pulse_driven;
		state == PLC_PULSE ##1 load_sink_pin == {$past(load_high_current_code), 1'b0};
	endsequence

	pulse_entry_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		arm_seen |=> pulse_driven or (state == PLC_PULSE && cooling))
		else $error("threshold crossing did not start high pulse");
	rise_clamp_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		reg_wr && reg_addr == `PLC_ADDR_RISE && reg_wdata[7:0] == 8'hFF
		|=> rising_threshold == `PLC_RISE_MAX)
		else $error("threshold top clamp failed");
	low_clamp_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		reg_wr && reg_addr == `PLC_ADDR_LOW && reg_wdata[5:0] == 6'h00
		|=> load_low_current_code == 6'h01)
		else $error("low code zero clamp failed");
	time_clamp_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		reg_wr && reg_addr == `PLC_ADDR_TIME && reg_wdata[11:0] == 12'h000
		|=> load_high_pulse_time == 12'h001)
		else $error("high time zero clamp failed");
	low_level_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		adc_live && !pulse_on |=> load_sink_pin == {5'h00, $past(load_low_current_code)})
		else $error("low current not driven");
	high_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		load_idle_select && adc_live && !cooling
		|=> load_sink_pin == {$past(load_high_current_code), 1'b0} && pulse_active)
		else $error("high idle did not select high code");
	overvoltage_factor_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		adc_last == `PLC_ADC_FULL && overvoltage_factor == 2'h3 |-> scaled == 12'hFF0)
		else $error("overvoltage scale wrong");
	cool_drain_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		step_tick && !pulse_on && acc > ACC_W'(cool_decrement)
		|=> acc == $past(acc) - ACC_W'($past(cool_decrement)))
		else $error("accumulator not decremented");
	cool_entry_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		!cooling && cool_period_seconds != 4'h0 && acc > limit_scaled |=> cooling)
		else $error("cool-down not entered over limit");
	cool_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		cool_period_seconds == 4'h0 |=> !cooling)
		else $error("cool-down active while disabled");
	cool_quiet_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		cooling |-> !pulse_on ##1 !pulse_active)
		else $error("pulse driven during cool-down");
endmodule
`default_nettype wire

// ===== sim/plc_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module plc_top_tb_top import plc_pkg::*; ;
	typedef struct packed {logic wr; plc_addr_t a; plc_word_t d; plc_word_t e;} plc_tb_row_t;

	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	plc_addr_t reg_addr = 10'h000;
	plc_word_t reg_wdata = 16'h0000;
	logic adc_valid = 1'b0;
	logic [7:0] adc_sample = 8'h00;
	plc_word_t reg_rdata;
	logic [10:0] load_sink_pin;
	logic pulse_active;
	logic cool_active;
	int n_errors = 0;
	int n_tests = 0;

	// ----------------------------------------
	// Register cases: reset reads first, then write and read back
	// ----------------------------------------
	plc_tb_row_t rows [20] = '{
		'{1'b0, 10'h010, 16'h0000, 16'h0000}, '{1'b0, 10'h011, 16'h0000, 16'h001E},
		'{1'b0, 10'h012, 16'h0000, 16'h001E}, '{1'b0, 10'h013, 16'h0000, 16'h00C8},
		'{1'b0, 10'h014, 16'h0000, 16'h012C}, '{1'b0, 10'h015, 16'h0000, 16'h0505},
		'{1'b0, 10'h016, 16'h0000, 16'h9BA3}, '{1'b0, 10'h017, 16'h0000, 16'h0000},
		'{1'b1, 10'h011, 16'h0000, 16'h0001}, '{1'b1, 10'h011, 16'h00FF, 16'h00FE},
		'{1'b1, 10'h011, 16'hAB40, 16'h0040}, '{1'b1, 10'h012, 16'h0000, 16'h0001},
		'{1'b1, 10'h012, 16'hFFFF, 16'h003F}, '{1'b1, 10'h013, 16'hFFFF, 16'h03FF},
		'{1'b1, 10'h014, 16'h0000, 16'h0001}, '{1'b1, 10'h014, 16'hFFFF, 16'h0FFF},
		'{1'b1, 10'h015, 16'hA5C3, 16'hA5C3}, '{1'b1, 10'h010, 16'hFFFF, 16'h0001},
		'{1'b1, 10'h016, 16'h1234, 16'h1234}, '{1'b1, 10'h017, 16'h1234, 16'h0000}};
	int tm [2] = '{0, 3};

	always #5 core_clk = ~core_clk;

	// Short tick and second keep the cool-down run brief
	plc_top #(.TICK_CYC(10), .SEC_TICKS(20), .ACC_W(24)) i_plc_top (
		.core_clk(core_clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.adc_valid(adc_valid), .adc_sample(adc_sample), .load_sink_pin(load_sink_pin),
		.pulse_active(pulse_active), .cool_active(cool_active));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	task automatic chk_rng(input int v, input int lo, input int hi, input string m);
		n_tests++;
		if (v < lo || v > hi) begin
			n_errors++;
			$display("wrong value at %0t: %s took %0d outside %0d..%0d", $time, m, v, lo, hi);
		end
	endtask

	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input plc_addr_t a, input plc_word_t d);
		@(posedge core_clk);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		tick(1);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input plc_addr_t a, output plc_word_t q);
		@(posedge core_clk);
		#1;
		reg_rd = 1'b1;
		reg_addr = a;
		tick(1);
		reg_rd = 1'b0;
		q = reg_rdata;
	endtask

	task automatic smp(input logic [7:0] v);
		@(posedge core_clk);
		#1;
		adc_valid = 1'b1;
		adc_sample = v;
		tick(1);
		adc_valid = 1'b0;
	endtask

	function automatic logic hit(input int sel);
		case (sel)
			0: return pulse_active === 1'b1;
			1: return pulse_active === 1'b0;
			2: return cool_active === 1'b1;
			default: return cool_active === 1'b0;
		endcase
	endfunction

	task automatic await(input int sel, input int lim, output int n);
		n = 0;
		while (!hit(sel) && n < lim) begin
			tick(1);
			n++;
		end
		chk_rng(n, 0, lim - 1, "wait for status");
	endtask

	task automatic do_reset;
		reset_n = 1'b0;
		tick(16);
		chk(16'({reg_rdata[0], pulse_active, cool_active, load_sink_pin}), 16'h0000, "reset outputs");
		reset_n = 1'b1;
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		print_verdict;
	end

	initial begin
		plc_word_t q;
		int n, u, f, k, hot;
		do_reset;
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				wr(rows[i].a, rows[i].d);
			end
			rd(rows[i].a, q);
			chk(q, rows[i].e, "register");
		end
		$display("register test done");

		// ----------------------------------------
		// Low idle: threshold, pulse length, spent state
		// ----------------------------------------
		wr(10'h010, 16'h0000);
		wr(10'h011, 16'h0040);
		wr(10'h012, 16'h000A);
		wr(10'h013, 16'h0064);
		wr(10'h015, 16'h0000);
		foreach (tm[j]) begin
			u = (tm[j] == 0) ? 1 : tm[j];
			wr(10'h014, 16'(tm[j]));
			smp(8'h10);
			tick(2);
			chk(16'(load_sink_pin), 16'h000A, "low code");
			// Equal to threshold is not above it
			smp(8'h40);
			tick(3);
			chk(16'(pulse_active), 16'h0000, "pulse at threshold");
			smp(8'h41);
			await(0, 10, n);
			chk(16'(load_sink_pin), 16'h00C8, "high code");
			await(1, 200, n);
			chk_rng(n, u * 10 - 2, u * 10 + 12, "pulse length");
			tick(2);
			chk(16'(load_sink_pin), 16'h000A, "after pulse");
		end
		smp(8'h00);
		tick(2);
		chk(16'(load_sink_pin), 16'h0000, "zero sample");
		wr(10'h010, 16'h0001);
		smp(8'h05);
		tick(2);
		chk({pulse_active, 4'h0, load_sink_pin}, 16'h80C8, "high idle");
		smp(8'h00);
		tick(2);
		chk(16'(load_sink_pin), 16'h0000, "high idle zero");
		$display("load test done");

		// ----------------------------------------
		// Energy meter: each scale reaches limit 16*128 in its own tick count
		// ----------------------------------------
		for (int ov = 0; ov < 4; ov++) begin
			f = (ov == 0) ? 1 : (2 << ov);
			n = 2048 / (255 * f) + 1;
			do_reset;
			wr(10'h010, 16'h0001);
			wr(10'h016, 16'h0010);
			wr(10'h015, 16'h0101 | 16'(ov << 6));
			smp(8'hFF);
			await(0, 10, k);
			await(2, 200, k);
			chk_rng(k, (n - 1) * 10, n * 10 + 5, "cool entry");
		end
		tick(2);
		chk({pulse_active, 4'h0, load_sink_pin}, 16'h001E, "cool load");
		await(3, 400, k);
		chk_rng(k, 185, 212, "cool period");
		// Accumulator is still over the limit, so cooling resumes
		await(2, 40, k);
		wr(10'h015, 16'h01F0);
		tick(1);
		hot = 0;
		repeat (50) begin
			hot += int'(cool_active !== 1'b0);
			tick(1);
		end
		chk_rng(hot, 0, 0, "cool disabled");
		// Longest timestep drains with the sample at zero
		smp(8'h00);
		tick(100);
		chk(16'({cool_active, load_sink_pin}), 16'h0000, "drain idle");
		$display("energy test done");
		print_verdict;
	end
endmodule

`default_nettype wire
